// ===== verilog/sebs_device.sv
`timescale 1ns/100ps
`include "sebs_regs.svh"
module sebs_device #(
  parameter int         WR_CYCLES = `SEBS_WR_STD_CYC,
  parameter bit         FAST_MODE = 1'b0,
  parameter logic [3:0] DEV_TYPE  = `SEBS_DEV_TYPE
) (
  // System side
  input  logic clk,
  input  logic rst,
  output logic wr_busy,
  output logic wr_done,
  // Link side
  input  logic link_clk,
  sebs_if.device bus
);
  import sebs_pkg::*;

  localparam logic [19:0] WR_LAST = 20'(WR_CYCLES - 1);
  localparam logic [2:0]  FILT    =
    3'(FAST_MODE ? `SEBS_FILT_FAST : `SEBS_FILT_STD);

  sebs_dev_s  r;
  sebs_dev_s  n;
  sebs_usr_s  u;
  sebs_usr_s  un;
  logic [7:0] mem [0:2047];
  logic [7:0] rd_byte;
  logic       mem_we;
  logic       do_load;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_seen;
  logic       stop_seen;

  // ============================================================
  // Bus conditions from filtered levels, bit 1 is SCL, bit 0 is SDA
  assign scl_rise   = r.flt[1] & ~r.flt_d[1];
  assign scl_fall   = ~r.flt[1] & r.flt_d[1];
  assign start_seen = r.flt[1] & r.flt_d[1] & r.flt_d[0] & ~r.flt[0];
  assign stop_seen  = r.flt[1] & r.flt_d[1] & ~r.flt_d[0] & r.flt[0];
  assign rd_byte    = mem[r.ptr];

  // ============================================================
  // Link domain
  always_comb begin
    n       = r;
    mem_we  = 1'b0;
    do_load = 1'b0;
    n.rs1   = rst;
    n.rs2   = r.rs1;
    n.s1    = {bus.scl, bus.sda};
    n.s2    = r.s1;
    n.flt_d = r.flt;
    // A level is taken only after FILT equal samples in a row
    for (int k = 0; k < 2; k++) begin
      if (r.s2[k] == r.flt[k]) begin
        n.cnt[k] = 3'h0;
      end else if (r.cnt[k] == FILT - 3'h1) begin
        n.flt[k] = r.s2[k];
        n.cnt[k] = 3'h0;
      end else begin
        n.cnt[k] = r.cnt[k] + 3'h1;
      end
    end
    if (r.st == d_busy) begin
      // Inputs stay deaf until the timer runs out
      if (r.tmr == WR_LAST) begin
        n.st       = d_idle;
        n.busy     = 1'b0;
        n.done_tgl = ~r.done_tgl;
      end else begin
        n.tmr = r.tmr + 20'h1;
      end
    end else if (stop_seen) begin
      n.sda_oe = 1'b0;
      n.bits   = 4'h0;
      if (r.wrote) begin
        n.st    = d_busy;
        n.busy  = 1'b1;
        n.tmr   = 20'h0;
        n.wrote = 1'b0;
      end else begin
        n.st = d_idle;
      end
    end else if (start_seen) begin
      n.st     = d_devadr;
      n.bits   = 4'h0;
      n.sda_oe = 1'b0;
    end else begin
      unique case (r.st)
        d_idle, d_wait, d_busy: begin
        end
        d_devadr, d_word, d_data: begin
          if (scl_rise) begin
            n.shr  = {r.shr[6:0], r.flt[0]};
            n.bits = r.bits + 4'h1;
          end
          if (scl_fall && r.bits == 4'h8) begin
            n.bits   = 4'h0;
            n.st     = d_ack;
            n.sda_oe = 1'b1;
            if (r.st == d_devadr) begin
              if (r.shr[`SEBS_TYPE_MSB:`SEBS_TYPE_LSB] == DEV_TYPE) begin
                n.rw          = r.shr[`SEBS_RW_BIT];
                n.ptr[10:8]   = r.shr[`SEBS_BLK_MSB:`SEBS_BLK_LSB];
                n.aft         = r.shr[`SEBS_RW_BIT] ? d_send : d_word;
              end else begin
                n.st     = d_wait;
                n.sda_oe = 1'b0;
              end
            end else if (r.st == d_word) begin
              n.ptr[7:0] = r.shr;
              n.aft      = d_data;
            end else begin
              // Address wraps inside the 16-byte page
              mem_we  = 1'b1;
              n.ptr[`SEBS_PAGE_MSB:0] = r.ptr[`SEBS_PAGE_MSB:0] + 4'h1;
              n.wrote = 1'b1;
              n.aft   = d_data;
            end
          end
        end
        d_ack: begin
          if (scl_fall) begin
            if (r.aft == d_send) begin
              do_load = 1'b1;
            end else begin
              n.sda_oe = 1'b0;
              n.st     = r.aft;
            end
          end
        end
        d_send: begin
          if (scl_rise) begin
            n.bits = r.bits + 4'h1;
          end
          if (scl_fall) begin
            if (r.bits == 4'h8) begin
              n.sda_oe = 1'b0;
              n.bits   = 4'h0;
              n.st     = d_mack;
            end else begin
              n.shr    = {r.shr[6:0], 1'b1};
              n.sda_oe = ~r.shr[6];
            end
          end
        end
        d_mack: begin
          if (scl_rise) begin
            n.mack = ~r.flt[0];
          end
          if (scl_fall) begin
            if (r.mack) begin
              do_load = 1'b1;
            end else begin
              n.st = d_wait;
            end
          end
        end
      endcase
    end
    if (do_load) begin
      // Sequential read runs over the whole array
      n.shr    = rd_byte;
      n.sda_oe = ~rd_byte[7];
      n.ptr    = r.ptr + 11'h1;
      n.bits   = 4'h0;
      n.st     = d_send;
    end
    if (r.rs2) begin
      n       = '0;
      n.flt   = 2'h3;
      n.flt_d = 2'h3;
      n.rs1   = rst;
      n.rs2   = r.rs1;
      n.s1    = {bus.scl, bus.sda};
      n.s2    = r.s1;
      mem_we  = 1'b0;
    end
  end

  always_ff @(posedge link_clk) begin
    r <= n;
  end

  always_ff @(posedge link_clk) begin
    if (mem_we) begin
      mem[r.ptr] <= r.shr;
    end
  end

  // ============================================================
  // System domain: busy level and completion toggle cross here
  always_comb begin
    un      = u;
    un.b1   = r.busy;
    un.b2   = u.b1;
    un.t1   = r.done_tgl;
    un.t2   = u.t1;
    un.t3   = u.t2;
    un.done = u.t2 ^ u.t3;
    if (rst) begin
      un.b2   = 1'b0;
      un.t2   = 1'b0;
      un.t3   = 1'b0;
      un.done = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    u <= un;
  end

  assign bus.dev_sda_o  = r.sda_o;
  assign bus.dev_sda_oe = r.sda_oe;
  assign wr_busy        = u.b2;
  assign wr_done        = u.done;
endmodule

// ===== verilog/sebs_regs.svh
`ifndef SEBS_REGS_SVH
`define SEBS_REGS_SVH

// ============================================================
// Slave address layout
`define SEBS_TYPE_MSB 7
`define SEBS_TYPE_LSB 4
`define SEBS_BLK_MSB 3
`define SEBS_BLK_LSB 1
`define SEBS_RW_BIT 0
// Memory-type code; the value is arbitrary
`define SEBS_DEV_TYPE 4'h6
// Offset bits inside one programming page
`define SEBS_PAGE_MSB 3

// ============================================================
// Timing
`define SEBS_CLK_KHZ 40000
`define SEBS_SCL_KHZ 100
`define SEBS_QTR_CYC (`SEBS_CLK_KHZ / (4 * `SEBS_SCL_KHZ))
`define SEBS_LINK_NS 30
`define SEBS_GLITCH_STD_NS 100
`define SEBS_GLITCH_FAST_NS 50
`define SEBS_FILT_STD \
  ((`SEBS_GLITCH_STD_NS + `SEBS_LINK_NS - 1) / `SEBS_LINK_NS + 1)
`define SEBS_FILT_FAST \
  ((`SEBS_GLITCH_FAST_NS + `SEBS_LINK_NS - 1) / `SEBS_LINK_NS + 1)
`define SEBS_WR_STD_MS 10
`define SEBS_WR_LV_MS 15
`define SEBS_WR_STD_CYC (`SEBS_WR_STD_MS * 1000000 / `SEBS_LINK_NS)
`define SEBS_WR_LV_CYC (`SEBS_WR_LV_MS * 1000000 / `SEBS_LINK_NS)

`endif

// ===== verilog/sebs_pkg.sv
package sebs_pkg;

  // ============================================================
  // Device end
  typedef enum logic [3:0] {
    d_idle   = 4'h0,
    d_devadr = 4'h1,
    d_ack    = 4'h3,
    d_word   = 4'h2,
    d_data   = 4'h6,
    d_send   = 4'h7,
    d_mack   = 4'h5,
    d_wait   = 4'h4,
    d_busy   = 4'hc
  } sebs_dev_e;

  typedef struct packed {
    logic            rs1;
    logic            rs2;
    logic [1:0]      s1;
    logic [1:0]      s2;
    logic [1:0]      flt;
    logic [1:0]      flt_d;
    logic [1:0][2:0] cnt;
    sebs_dev_e       st;
    sebs_dev_e       aft;
    logic [3:0]      bits;
    logic [7:0]      shr;
    logic            rw;
    logic [10:0]     ptr;
    logic            wrote;
    logic            mack;
    logic            sda_o;
    logic            sda_oe;
    logic [19:0]     tmr;
    logic            busy;
    logic            done_tgl;
  } sebs_dev_s;

  typedef struct packed {
    logic b1;
    logic b2;
    logic t1;
    logic t2;
    logic t3;
    logic done;
  } sebs_usr_s;

  // ============================================================
  // Host end
  typedef enum logic [1:0] {
    h_idle  = 2'h0,
    h_start = 2'h1,
    h_bit   = 2'h3,
    h_stop  = 2'h2
  } sebs_host_e;

  typedef struct packed {
    sebs_host_e st;
    logic [1:0] q;
    logic [6:0] qc;
    logic [1:0] step;
    logic [3:0] i;
    logic [7:0] tx;
    logic [7:0] rx;
    logic       ackb;
    logic       rd;
    logic [2:0] blk;
    logic [7:0] word;
    logic [7:0] wdata;
    logic       sd1;
    logic       sd2;
    logic       scl_o;
    logic       scl_oe;
    logic       sda_o;
    logic       sda_oe;
    logic       req_ready;
    logic       resp_valid;
    logic       resp_nack;
    logic [7:0] resp_rdata;
  } sebs_host_s;

endpackage

// ===== verilog/sebs_if.sv
`timescale 1ns/100ps
interface sebs_if;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic scl;
  logic sda;

  // ============================================================
  // Open-drain wires with pull-up
  assign scl = ~(host_scl_oe & ~host_scl_o);
  assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));

  modport host (
    output host_scl_o,
    output host_scl_oe,
    output host_sda_o,
    output host_sda_oe,
    input  sda
  );

  modport device (
    input  scl,
    input  sda,
    output dev_sda_o,
    output dev_sda_oe
  );
endinterface

// ===== verilog/sebs_host.sv
`timescale 1ns/100ps
`include "sebs_regs.svh"
module sebs_host #(
  parameter logic [3:0] DEV_TYPE = `SEBS_DEV_TYPE
) (
  // System
  input  logic       clk,
  input  logic       rst,
  // Requests
  input  logic       req_valid,
  output logic       req_ready,
  input  logic       req_read,
  input  logic [2:0] req_block,
  input  logic [7:0] req_word,
  input  logic [7:0] req_wdata,
  // Answers
  output logic       resp_valid,
  output logic       resp_nack,
  output logic [7:0] resp_rdata,
  // Link
  sebs_if.host       bus
);
  import sebs_pkg::*;

  localparam logic [6:0] QTR_LAST = 7'(`SEBS_QTR_CYC - 1);

  sebs_host_s r;
  sebs_host_s n;
  logic       tick;
  logic       recv;

  function automatic logic [7:0] byte_of(input sebs_host_s s,
                                         input logic [1:0] k);
    case (k)
      2'h0: byte_of = {DEV_TYPE, s.blk, 1'b0};
      2'h1: byte_of = s.word;
      2'h2: byte_of = s.rd ? {DEV_TYPE, s.blk, 1'b1} : s.wdata;
      2'h3: byte_of = 8'hff;
    endcase
  endfunction

  assign tick   = r.qc == QTR_LAST;
  assign recv   = r.rd && r.step == 2'h3;

  // ============================================================
  // Each bus item is four quarter periods; SCL low in q0 and q1
  always_comb begin
    n            = r;
    n.resp_valid = 1'b0;
    n.sd1        = bus.sda;
    n.sd2        = r.sd1;
    unique case (r.st)
      h_idle: begin
        n.req_ready = 1'b1;
        if (req_valid && r.req_ready) begin
          n.rd        = req_read;
          n.blk       = req_block;
          n.word      = req_word;
          n.wdata     = req_wdata;
          n.st        = h_start;
          n.step      = 2'h0;
          n.q         = 2'h0;
          n.qc        = 7'h0;
          n.req_ready = 1'b0;
          n.resp_nack = 1'b0;
        end
      end
      h_start, h_bit, h_stop: begin
        n.qc = tick ? 7'h0 : r.qc + 7'h1;
        if (tick) begin
          n.q = r.q + 2'h1;
          if (r.q == 2'h2 && r.st == h_bit) begin
            if (r.i == 4'h8) begin
              n.ackb = r.sd2;
            end else begin
              n.rx = {r.rx[6:0], r.sd2};
            end
          end
          if (r.q == 2'h3) begin
            if (r.st == h_start) begin
              n.st = h_bit;
              n.i  = 4'h0;
              n.tx = byte_of(r, r.step);
            end else if (r.st == h_stop) begin
              n.st         = h_idle;
              n.resp_valid = 1'b1;
              n.resp_rdata = r.rx;
            end else if (r.i != 4'h8) begin
              n.i  = r.i + 4'h1;
              n.tx = {r.tx[6:0], 1'b1};
            end else if (!recv && r.ackb) begin
              // No acknowledge: give up and release the bus
              n.st        = h_stop;
              n.resp_nack = 1'b1;
            end else if (r.step == (r.rd ? 2'h3 : 2'h2)) begin
              n.st = h_stop;
            end else begin
              n.step = r.step + 2'h1;
              n.i    = 4'h0;
              n.tx   = byte_of(r, 2'(r.step + 2'h1));
              n.st   = (r.rd && r.step == 2'h1) ? h_start : h_bit;
            end
          end
        end
      end
    endcase
    // SDA only moves at q1 while SCL is low, except start and stop
    n.scl_oe = (n.st != h_idle) && !n.q[1];
    if (n.st == h_idle) begin
      n.sda_oe = 1'b0;
    end else if (n.q != 2'h0) begin
      if (n.st == h_start) begin
        n.sda_oe = n.q == 2'h3;
      end else if (n.st == h_stop) begin
        n.sda_oe = n.q != 2'h3;
      end else begin
        // Last read byte is left without acknowledge
        // Next state is read inline; a net fed back from n would loop
        n.sda_oe = !((n.rd && n.step == 2'h3) || n.i == 4'h8)
                   && !n.tx[7];
      end
    end
    if (rst) begin
      n     = '0;
      n.sd1 = bus.sda;
      n.sd2 = r.sd1;
    end
  end

  always_ff @(posedge clk) begin
    r <= n;
  end

  assign bus.host_scl_o  = r.scl_o;
  assign bus.host_scl_oe = r.scl_oe;
  assign bus.host_sda_o  = r.sda_o;
  assign bus.host_sda_oe = r.sda_oe;
  assign req_ready       = r.req_ready;
  assign resp_valid      = r.resp_valid;
  assign resp_nack       = r.resp_nack;
  assign resp_rdata      = r.resp_rdata;
endmodule

// ===== verilog/sebs_end.sv
`timescale 1ns/100ps

// ===== sim/sebs_chk.sv
`timescale 1ns/100ps
module sebs_chk #(
  parameter int BUSY_MAX = 260
) (
  // System side
  input logic clk,
  input logic rst,
  input logic wr_busy,
  input logic wr_done,
  // Link side
  input logic link_clk,
  input logic host_scl_o,
  input logic host_scl_oe,
  input logic host_sda_o,
  input logic host_sda_oe,
  input logic dev_sda_o,
  input logic dev_sda_oe,
  input logic scl,
  input logic sda
);
  logic [15:0] busy_cnt_reg;
  logic [3:0]  link_rst_reg;
  logic        link_rst;

  // ============================================================
  // Link-side reset: the device leaves reset some link cycles after
  // rst falls, so link checks must not look back into that time
  always_ff @(posedge link_clk) begin
    link_rst_reg <= {link_rst_reg[2:0], rst};
  end

  assign link_rst = rst | (|link_rst_reg);

  // ============================================================
  // Busy length, counted in system cycles
  always_ff @(posedge clk) begin
    if (rst || !wr_busy) busy_cnt_reg <= 16'h0000;
    else busy_cnt_reg <= busy_cnt_reg + 16'h0001;
  end

  // ============================================================
  // Link domain
  property p_open_drain;
    @(posedge link_clk) disable iff (link_rst)
      !host_scl_o && !host_sda_o && !dev_sda_o;
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("open-drain pin driven high");

  property p_hold_high;
    @(posedge link_clk) disable iff (link_rst)
      scl && $past(scl) |-> $stable(dev_sda_oe);
  endproperty
  a_hold_high: assert property (p_hold_high)
    else $error("device changed SDA while SCL high");

  property p_ack_low;
    @(posedge link_clk) disable iff (link_rst)
      $rose(dev_sda_oe) |-> !scl ##1 !scl;
  endproperty
  a_ack_low: assert property (p_ack_low)
    else $error("device pulled SDA outside SCL low");

  property p_rel_low;
    @(posedge link_clk) disable iff (link_rst)
      $fell(dev_sda_oe) |-> !scl;
  endproperty
  a_rel_low: assert property (p_rel_low)
    else $error("device released SDA outside SCL low");

  property p_after_start;
    @(posedge link_clk) disable iff (link_rst)
      scl && $fell(sda) |=> !dev_sda_oe [*8];
  endproperty
  a_after_start: assert property (p_after_start)
    else $error("device drove SDA right after start");

  property p_after_stop;
    @(posedge link_clk) disable iff (link_rst)
      scl && $rose(sda) |=> !dev_sda_oe [*8];
  endproperty
  a_after_stop: assert property (p_after_stop)
    else $error("device drove SDA right after stop");

  // ============================================================
  // System domain
  property p_busy_quiet;
    @(posedge clk) disable iff (rst)
      wr_busy |-> !dev_sda_oe;
  endproperty
  a_busy_quiet: assert property (p_busy_quiet)
    else $error("device drove SDA while busy");

  property p_busy_len;
    @(posedge clk) disable iff (rst)
      busy_cnt_reg <= BUSY_MAX;
  endproperty
  a_busy_len: assert property (p_busy_len)
    else $error("write cycle too long");

  property p_done_pulse;
    @(posedge clk) disable iff (rst)
      wr_done |=> !wr_done;
  endproperty
  a_done_pulse: assert property (p_done_pulse)
    else $error("done longer than one cycle");

  property p_done_end;
    @(posedge clk) disable iff (rst)
      wr_done |-> ##[0:6] !wr_busy;
  endproperty
  a_done_end: assert property (p_done_end)
    else $error("busy stayed after done");
endmodule

// ===== sim/serial_eeprom_bus_slave_tb.sv
`timescale 1ns/100ps
module serial_eeprom_bus_slave_tb;
  import sebs_pkg::*;
  // Write cycle must outlast the next start (about 400 clk after the
  // stop) yet end before the read-back starts (about 4800 clk after)
  localparam int WR = 2000;
  logic       clk         = 1'b0;
  logic       link_clk    = 1'b0;
  logic       rst         = 1'b1;
  logic       req_valid   = 1'b0;
  logic       req_valid_b = 1'b0;
  logic       req_read    = 1'b0;
  logic [2:0] req_block   = 3'h0;
  logic [7:0] req_word    = 8'h00;
  logic [7:0] req_wdata   = 8'h00;
  logic       saw_busy    = 1'b0;
  logic       req_ready, req_ready_b, resp_valid, resp_valid_b;
  logic       resp_nack, resp_nack_b, wr_busy, wr_done, nack;
  logic [7:0] resp_rdata, rdata;
  int         n_errors    = 0;
  int         n_checks    = 0;
  int         n_done      = 0;
  int         cycles      = 0;

  sebs_if if_a ();
  sebs_if if_b ();

  sebs_device #(.WR_CYCLES(WR)) sebs_device_i (.clk(clk), .rst(rst),
    .wr_busy(wr_busy), .wr_done(wr_done), .link_clk(link_clk), .bus(if_a));
  sebs_host sebs_host_i (.clk(clk), .rst(rst), .req_valid(req_valid),
    .req_ready(req_ready), .req_read(req_read), .req_block(req_block),
    .req_word(req_word), .req_wdata(req_wdata), .resp_valid(resp_valid),
    .resp_nack(resp_nack), .resp_rdata(resp_rdata), .bus(if_a));
  // Second pair: host asks for another type code, so no answer is due
  sebs_host #(.DEV_TYPE(4'h9)) sebs_host_b_i (.clk(clk), .rst(rst),
    .req_valid(req_valid_b), .req_ready(req_ready_b), .req_read(req_read),
    .req_block(req_block), .req_word(req_word), .req_wdata(req_wdata),
    .resp_valid(resp_valid_b), .resp_nack(resp_nack_b), .resp_rdata(),
    .bus(if_b));
  // Only the second device runs the short glitch window
  sebs_device #(.WR_CYCLES(WR), .FAST_MODE(1'b1)) sebs_device_b_i (
    .clk(clk), .rst(rst), .wr_busy(), .wr_done(), .link_clk(link_clk),
    .bus(if_b));
  sebs_chk #(.BUSY_MAX(WR * 30 / 25 + 10)) sebs_chk_i (.clk(clk),
    .rst(rst), .wr_busy(wr_busy), .wr_done(wr_done), .link_clk(link_clk),
    .host_scl_o(if_a.host_scl_o), .host_scl_oe(if_a.host_scl_oe),
    .host_sda_o(if_a.host_sda_o), .host_sda_oe(if_a.host_sda_oe),
    .dev_sda_o(if_a.dev_sda_o), .dev_sda_oe(if_a.dev_sda_oe),
    .scl(if_a.scl), .sda(if_a.sda));

  // ============================================================
  // Clocks, unrelated in phase
  always #12.5 clk = ~clk;
  initial begin
    #7;
    forever #15 link_clk = ~link_clk;
  end

  // ============================================================
  // Tasks
  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks = n_checks + 1;
    if (seen !== exp) begin
      n_errors = n_errors + 1;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One transaction; the request is held until the edge that takes it
  task automatic xfer(input logic rd, input logic [2:0] blk,
                      input logic [7:0] wd, input logic [7:0] dat,
                      input logic both);
    req_valid = 1'b1;
    req_valid_b = both;
    req_read = rd;
    req_block = blk;
    req_word = wd;
    req_wdata = dat;
    while (req_ready !== 1'b1) begin
      @(posedge clk);
      #1;
    end
    @(posedge clk);
    #1;
    req_valid = 1'b0;
    req_valid_b = 1'b0;
    do begin
      @(posedge clk);
      #1;
    end while (resp_valid !== 1'b1);
    nack = resp_nack;
    rdata = resp_rdata;
  endtask

  // ============================================================
  // Watchers and timeout
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (wr_done === 1'b1) n_done <= n_done + 1;
    if (wr_busy === 1'b1) saw_busy <= 1'b1;
    if (resp_valid_b === 1'b1) check({7'h00, resp_nack_b}, 8'h01);
    if (cycles == 90000) begin
      n_errors = n_errors + 1;
      report_and_stop();
    end
  end

  // ============================================================
  // Tests
  initial begin
    repeat (4) @(posedge clk);
    #1 rst = 1'b0;
    repeat (20) @(posedge clk);
    #1;
    xfer(1'b0, 3'h5, 8'h3c, 8'ha5, 1'b1);
    check({7'h00, nack}, 8'h00);
    $display("test byte write done");
    // Issued right after the stop, while the write cycle runs
    xfer(1'b1, 3'h5, 8'h3c, 8'h00, 1'b0);
    check({7'h00, nack}, 8'h01);
    check({7'h00, saw_busy}, 8'h01);
    check(n_done[7:0], 8'h01);
    $display("test busy refusal done");
    xfer(1'b1, 3'h5, 8'h3c, 8'h00, 1'b0);
    check({7'h00, nack}, 8'h00);
    check(rdata, 8'ha5);
    $display("test read back done");
    xfer(1'b0, 3'h2, 8'h3c, 8'h5a, 1'b0);
    while (n_done != 2) @(posedge clk);
    #1;
    xfer(1'b1, 3'h2, 8'h3c, 8'h00, 1'b0);
    check(rdata, 8'h5a);
    xfer(1'b1, 3'h5, 8'h3c, 8'h00, 1'b0);
    check(rdata, 8'ha5);
    $display("test block select done");
    report_and_stop();
  end
endmodule
